// >>> hdl/uart_aux_pkg.sv
// package: register map, field positions, reset values and carriers of the aux register bank
package uart_aux_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODEM_LINE_STATUS = 8'h00;
    localparam logic [7:0] ADDR_SCRATCH_BYTE = 8'h04;
    localparam logic [7:0] ADDR_FLOW_THRESHOLD = 8'h08;
    localparam logic [7:0] ADDR_TRIGGER_LEVEL = 8'h0C;
    localparam logic [7:0] ADDR_TX_FREE_SPACE = 8'h10;
    localparam logic [7:0] ADDR_RX_FILL = 8'h14;
    localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h18;
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h1C;
    localparam logic [7:0] ADDR_PIN_IRQ_ENABLE = 8'h20;
    localparam logic [7:0] ADDR_AUX_CONTROL = 8'h24;
    localparam logic [7:0] ADDR_PIN_CHANGE = 8'h28;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MSR_CTS_BIT = 4;
    localparam int MSR_DSR_BIT = 5;
    localparam int MSR_RI_BIT = 6;
    localparam int MSR_CD_BIT = 7;
    localparam int MSR_DCTS_BIT = 0;
    localparam int MSR_DDSR_BIT = 1;
    localparam int MSR_TERI_BIT = 2;
    localparam int MSR_DCD_BIT = 3;
    // aux control fields
    localparam int CTL_LOW_MODEM_BIT = 2;
    localparam int CTL_HIGH_MODEM_BIT = 1;
    localparam int CTL_EFW_BIT = 8;
    localparam int CTL_TRE_BIT = 9;
    localparam int CTL_LOOP_BIT = 10;
    localparam int CTL_DTR_BIT = 11;
    localparam int CTL_RTS_BIT = 12;
    localparam int CTL_MSI_EN_BIT = 13;
    localparam int CTL_FCR_RXTRIG_LSB = 16;
    localparam int CTL_FCR_TXTRIG_LSB = 20;
    // gpio positions used in modem mode (low nibble, high nibble adds 4)
    localparam int GP_DSR_OFS = 0;
    localparam int GP_DTR_OFS = 1;
    localparam int GP_CD_OFS = 2;
    localparam int GP_RI_OFS = 3;
    localparam int NIB_SHIFT = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_CONTROL = 32'h0000_0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] resume_lvl;
        logic [3:0] halt_lvl;
    } flow_thr_s;

    typedef struct packed {
        logic [3:0] rx_lvl;
        logic [3:0] tx_lvl;
    } trig_lvl_s;

    // effective thresholds in characters, to the uart core
    typedef struct packed {
        logic [6:0] halt_cnt;
        logic [6:0] resume_cnt;
        logic [6:0] rx_trig_cnt;
        logic [6:0] tx_trig_cnt;
        logic use_fcr_flow;
    } levels_s;

    // raw active-low modem inputs
    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic ri_n;
        logic cd_n;
    } modem_in_s;

endpackage

// >>> hdl/uart_aux_regs.sv
// module: per-channel aux register bank (modem status, thresholds, levels, gpio) on apb

// Operation
// - cts status bit is inverted cts pin
// - modem-mode nibbles feed cd, ri, dsr status
// - pin level also shows modem pins
// - cd, dsr, cts change flags clear on read
// - ri flag sets on low-to-high only
// - scratch byte stores and returns value
// - threshold: halt low nibble, resume high
// - threshold nibble times four gives count
// - zero threshold selects fifo control levels
// - threshold writes need both enable bits
// - trigger: rx high nibble, tx low
// - zero trigger nibble selects fifo control
// - tx free space read-only, bit7 zero
// - rx fill count read-only, bit7 zero
// - direction bit one makes pin output outside modem nibbles
// - pin level reads all pins
// - pin level write drives output pins only
// - enable bit lets pin change interrupt
// - modem-mode nibble ignores pin enables
// - mode bits select io or modem per nibble
// - loopback feeds dtr, rts into dsr, cts
module uart_aux_regs
    import uart_aux_pkg::*;
#(
    parameter int GPIO_W = 8
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fifo levels from the uart core
    input wire logic [6:0] tx_space,
    input wire logic [6:0] rx_count,
    // dedicated modem pins, active low
    input wire logic cts_pin_n,
    // gpio pins
    input wire logic [GPIO_W-1:0] gpio_in,
    output logic [GPIO_W-1:0] gpio_out,
    output logic [GPIO_W-1:0] gpio_oe,
    // towards interrupt and flow logic
    output levels_s levels,
    output logic modem_irq,
    output logic pin_irq
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] scratch_ff; // free scratch byte
    flow_thr_s flow_ff; // halt/resume thresholds
    trig_lvl_s trig_ff; // interrupt trigger levels
    logic [GPIO_W-1:0] dir_ff; // pin directions
    logic [GPIO_W-1:0] lvl_ff; // written output levels
    logic [GPIO_W-1:0] ien_ff; // pin change irq enables
    logic [GPIO_W-1:0] pchg_ff; // sticky pin change flags
    logic [31:0] ctl_ff; // aux control word
    logic [3:0] dflag_ff; // msr change flags 3:0
    logic [3:0] mstat_ff; // previous status cd,ri,dsr,cts
    logic mvalid_ff; // previous status is meaningful
    logic [GPIO_W-1:0] gsync1_ff; // gpio first stage
    logic [GPIO_W-1:0] gsync2_ff; // gpio second stage
    logic [GPIO_W-1:0] gprev_ff; // gpio previous sample
    logic cts_s1_ff; // cts first stage
    logic cts_s2_ff; // cts second stage

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic wr_en; // write taken this edge
    logic rd_en; // read taken this edge
    logic tre_ok; // threshold registers writable
    logic [7:0] wb; // write byte

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign wb = pwdata[7:0];
    assign tre_ok = ctl_ff[CTL_EFW_BIT] && ctl_ff[CTL_TRE_BIT];

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    // two stages for every asynchronous pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gsync1_ff <= '0;
            gsync2_ff <= '0;
            cts_s1_ff <= 1'b1;
            cts_s2_ff <= 1'b1;
        end else begin
            gsync1_ff <= gpio_in;
            gsync2_ff <= gsync1_ff;
            cts_s1_ff <= cts_pin_n;
            cts_s2_ff <= cts_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // modem status bits
    // ------------------------------------------------------------
    logic lo_modem; // gpio 3:0 are modem pins
    logic hi_modem; // gpio 7:4 are modem pins
    logic loop_on; // internal loopback
    logic [3:0] mstat; // current cd,ri,dsr,cts (active high)
    logic [2:0] gp_stat; // cd,ri,dsr from selected gpio nibble
    logic gp_valid; // some nibble in modem mode

    assign lo_modem = ctl_ff[CTL_LOW_MODEM_BIT];
    assign hi_modem = ctl_ff[CTL_HIGH_MODEM_BIT];
    assign loop_on = ctl_ff[CTL_LOOP_BIT];
    assign gp_valid = lo_modem || hi_modem;

    // modem-mode pins, inverted; high nibble wins when both are set
    always_comb begin
        gp_stat = 3'b000;
        if (hi_modem) begin
            gp_stat = {~gsync2_ff[GP_CD_OFS + 4], ~gsync2_ff[GP_RI_OFS + 4],
                       ~gsync2_ff[GP_DSR_OFS + 4]};
        end else if (lo_modem) begin
            gp_stat = {~gsync2_ff[GP_CD_OFS], ~gsync2_ff[GP_RI_OFS],
                       ~gsync2_ff[GP_DSR_OFS]};
        end
    end

    // select loopback or pin sources
    always_comb begin
        if (loop_on) begin
            // dtr drives dsr, rts drives cts
            mstat = {2'b00, ctl_ff[CTL_DTR_BIT], ctl_ff[CTL_RTS_BIT]};
        end else begin
            mstat = {gp_stat, ~cts_s2_ff};
        end
    end

    // change detection against previous status
    logic [3:0] dset; // flags to set this cycle

    always_comb begin
        dset = 4'h0;
        if (mvalid_ff) begin
            dset[MSR_DCTS_BIT] = mstat[0] ^ mstat_ff[0];
            dset[MSR_DDSR_BIT] = mstat[1] ^ mstat_ff[1];
            // ri pin low to high means status high to low
            dset[MSR_TERI_BIT] = mstat_ff[2] && !mstat[2];
            dset[MSR_DCD_BIT] = mstat[3] ^ mstat_ff[3];
            if (!gp_valid && !loop_on) begin
                dset[MSR_DDSR_BIT] = 1'b0;
                dset[MSR_TERI_BIT] = 1'b0;
                dset[MSR_DCD_BIT] = 1'b0;
            end
        end
    end

    // history of modem status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstat_ff <= 4'h0;
            mvalid_ff <= 1'b0;
        end else begin
            mstat_ff <= mstat;
            mvalid_ff <= 1'b1;
        end
    end

    logic msr_rd; // modem status read this edge
    assign msr_rd = rd_en && (paddr == ADDR_MODEM_LINE_STATUS);

    // change flags: read clears, new change wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dflag_ff <= 4'h0;
        end else if (msr_rd) begin
            // clear only what the read reported, so a later change is not lost
            dflag_ff <= (dflag_ff & ~prdata[3:0]) | dset;
        end else begin
            dflag_ff <= dflag_ff | dset;
        end
    end

    // ------------------------------------------------------------
    // plain read/write registers
    // ------------------------------------------------------------
    // scratch byte, no side effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scratch_ff <= RST_BYTE;
        end else if (wr_en && paddr == ADDR_SCRATCH_BYTE) begin
            scratch_ff <= wb;
        end
    end

    // thresholds, writable only with both enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_ff <= RST_BYTE;
            trig_ff <= RST_BYTE;
        end else if (wr_en && tre_ok) begin
            if (paddr == ADDR_FLOW_THRESHOLD) begin
                flow_ff <= wb;
            end
            if (paddr == ADDR_TRIGGER_LEVEL) begin
                trig_ff <= wb;
            end
        end
    end

    // aux control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= RST_CONTROL;
        end else if (wr_en && paddr == ADDR_AUX_CONTROL) begin
            ctl_ff <= pwdata;
        end
    end

    // gpio direction, level and irq enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff <= '0;
            lvl_ff <= '0;
            ien_ff <= '0;
        end else if (wr_en) begin
            if (paddr == ADDR_PIN_DIRECTION) begin
                dir_ff <= wb[GPIO_W-1:0];
            end
            if (paddr == ADDR_PIN_LEVEL) begin
                lvl_ff <= wb[GPIO_W-1:0];
            end
            if (paddr == ADDR_PIN_IRQ_ENABLE) begin
                ien_ff <= wb[GPIO_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // gpio pin drive
    // ------------------------------------------------------------
    logic [GPIO_W-1:0] modem_mask; // pins owned by modem function
    logic [GPIO_W-1:0] dtr_mask; // dtr pins in modem nibbles

    assign modem_mask = {{4{hi_modem}}, {4{lo_modem}}};
    assign dtr_mask = modem_mask & 8'h22;

    // outputs follow level outside modem nibbles, enabled where direction says output there and always on modem dtr pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_out <= '0;
            gpio_oe <= '0;
        end else begin
            gpio_oe <= (dir_ff & ~modem_mask) | dtr_mask;
            // dtr pin active low from dtr control
            gpio_out <= (lvl_ff & ~modem_mask) | (dtr_mask & {8{~ctl_ff[CTL_DTR_BIT]}});
        end
    end

    // ------------------------------------------------------------
    // pin change interrupt
    // ------------------------------------------------------------
    logic [GPIO_W-1:0] pset; // enabled input changes
    // only input pins outside modem nibbles may raise a flag
    assign pset = (gsync2_ff ^ gprev_ff) & ~dir_ff & ien_ff & ~modem_mask;

    logic pchg_rd; // pin change register read
    assign pchg_rd = rd_en && (paddr == ADDR_PIN_CHANGE);

    // sticky flags, set wins over read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gprev_ff <= '0;
            pchg_ff <= '0;
        end else begin
            gprev_ff <= gsync2_ff;
            // a read clears only the flags that it reported
            pchg_ff <= (pchg_rd ? pchg_ff & ~prdata[GPIO_W-1:0] : pchg_ff) | pset;
        end
    end

    // interrupt lines to the channel's interrupt logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_irq <= 1'b0;
            modem_irq <= 1'b0;
        end else begin
            pin_irq <= |pchg_ff;
            modem_irq <= ctl_ff[CTL_MSI_EN_BIT] && (|dflag_ff);
        end
    end

    // ------------------------------------------------------------
    // effective levels
    // ------------------------------------------------------------
    logic [3:0] fcr_rx; // fifo control rx level, in fours
    logic [3:0] fcr_tx; // fifo control tx level, in fours

    assign fcr_rx = ctl_ff[CTL_FCR_RXTRIG_LSB +: 4];
    assign fcr_tx = ctl_ff[CTL_FCR_TXTRIG_LSB +: 4];

    // nibble times four, zero falls back to fifo control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // flow register resets to zero, so fifo control levels rule
            levels <= '{use_fcr_flow: 1'b1, default: '0};
        end else begin
            levels.halt_cnt <= {1'b0, flow_ff.halt_lvl, 2'b00};
            levels.resume_cnt <= {1'b0, flow_ff.resume_lvl, 2'b00};
            levels.use_fcr_flow <= (flow_ff == 8'h00);
            levels.rx_trig_cnt <= {1'b0, (trig_ff.rx_lvl != 4'h0) ? trig_ff.rx_lvl : fcr_rx,
                                   2'b00};
            levels.tx_trig_cnt <= {1'b0, (trig_ff.tx_lvl != 4'h0) ? trig_ff.tx_lvl : fcr_tx,
                                   2'b00};
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0] rd_byte; // selected read byte
    logic rd_hit; // address is mapped
    logic [31:0] rd_word; // full read word

    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (paddr)
            ADDR_MODEM_LINE_STATUS: rd_byte = {mstat, dflag_ff};
            ADDR_SCRATCH_BYTE: rd_byte = scratch_ff;
            ADDR_FLOW_THRESHOLD: rd_byte = flow_ff;
            ADDR_TRIGGER_LEVEL: rd_byte = trig_ff;
            ADDR_TX_FREE_SPACE: rd_byte = {1'b0, tx_space};
            ADDR_RX_FILL: rd_byte = {1'b0, rx_count};
            ADDR_PIN_DIRECTION: rd_byte = dir_ff;
            ADDR_PIN_LEVEL: rd_byte = gsync2_ff;
            ADDR_PIN_IRQ_ENABLE: rd_byte = ien_ff;
            ADDR_PIN_CHANGE: rd_byte = pchg_ff;
            ADDR_AUX_CONTROL: rd_word = ctl_ff;
            default: rd_hit = 1'b0;
        endcase
        if (paddr != ADDR_AUX_CONTROL) begin
            rd_word = {24'h000000, rd_byte};
        end
    end

    // answer every access in its first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

endmodule

// >>> testbench/uart_aux_regs_props.sv
// checker: apb timing, read-only counts and update causes of the aux register bank
module uart_aux_regs_props
    import uart_aux_pkg::*;
#(
    parameter int GPIO_W = 8
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // fifo levels and pins
    input wire logic [6:0] tx_space,
    input wire logic [6:0] rx_count,
    input wire logic cts_pin_n,
    input wire logic [GPIO_W-1:0] gpio_in,
    input wire logic [GPIO_W-1:0] gpio_out,
    input wire logic [GPIO_W-1:0] gpio_oe,
    // towards interrupt and flow logic
    input wire levels_s levels,
    input wire logic modem_irq,
    input wire logic pin_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------
    // helper terms
    // --------------------------------
    logic wr_any; // write access edge
    logic wr_pin; // write that may move gpio drivers
    logic clr_msi; // status read or control write
    logic rd_tx; // setup of a tx space read
    logic rd_rx; // setup of an rx fill read
    assign wr_any = psel && penable && pwrite;
    assign wr_pin = wr_any && (paddr == ADDR_PIN_DIRECTION || paddr == ADDR_PIN_LEVEL
        || paddr == ADDR_AUX_CONTROL);
    assign clr_msi = (psel && penable && !pwrite && paddr == ADDR_MODEM_LINE_STATUS)
        || (wr_any && paddr == ADDR_AUX_CONTROL);
    assign rd_tx = psel && !penable && !pwrite && paddr == ADDR_TX_FREE_SPACE;
    assign rd_rx = psel && !penable && !pwrite && paddr == ADDR_RX_FILL;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // --------------------------------
    // properties
    // --------------------------------
    property p_ready_two;
        psel && !penable |=> pready;
    endproperty
    a_ready_two: assert property (p_ready_two)
        else $error("pready missing in first access cycle");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_tx_count;
        rd_tx |=> prdata == {25'h0, $past(tx_space)};
    endproperty
    a_tx_count: assert property (p_tx_count)
        else $error("tx space read wrong");
    property p_rx_count;
        rd_rx |=> prdata == {25'h0, $past(rx_count)};
    endproperty
    a_rx_count: assert property (p_rx_count)
        else $error("rx fill read wrong");
    property p_oe_cause;
        !$stable(gpio_oe) |-> $past(wr_pin) || $past(wr_pin, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("gpio enable moved without a write");
    property p_out_cause;
        !$stable(gpio_out) |-> $past(wr_pin) || $past(wr_pin, 2);
    endproperty
    a_out_cause: assert property (p_out_cause)
        else $error("gpio output moved without a write");
    property p_irq_fall;
        $fell(modem_irq) |-> $past(clr_msi) || $past(clr_msi, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("modem irq dropped without a status read");
    property p_levels_hold;
        !$stable(levels) |-> $past(wr_any) || $past(wr_any, 2);
    endproperty
    a_levels_hold: assert property (p_levels_hold)
        else $error("levels moved without a write");
    property p_flow_step;
        levels.halt_cnt[1:0] == 2'b00 && levels.resume_cnt[1:0] == 2'b00;
    endproperty
    a_flow_step: assert property (p_flow_step)
        else $error("flow level not a multiple of four");
    property p_trig_step;
        levels.rx_trig_cnt[1:0] == 2'b00 && levels.tx_trig_cnt[1:0] == 2'b00;
    endproperty
    a_trig_step: assert property (p_trig_step)
        else $error("trigger level not a multiple of four");
    // main scenarios seen
    c_write: cover property (wr_any && pready);
    c_msi: cover property ($fell(modem_irq));
    c_pin: cover property ($rose(pin_irq));
    c_err: cover property (pslverr);
endmodule

bind uart_aux_regs uart_aux_regs_props #(.GPIO_W(GPIO_W)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_space(tx_space), .rx_count(rx_count), .cts_pin_n(cts_pin_n), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .levels(levels), .modem_irq(modem_irq),
    .pin_irq(pin_irq)
);

// >>> testbench/modem_line_peer.sv
// peer model: far-side modem and peripheral lines resolved against the bank's drivers
module modem_line_peer #(
    parameter int GPIO_W = 8
) (
    // bank side
    input wire logic [GPIO_W-1:0] gpio_out,
    input wire logic [GPIO_W-1:0] gpio_oe,
    output logic [GPIO_W-1:0] gpio_in,
    output logic cts_pin_n,
    // levels the far device puts on its lines
    input wire logic [GPIO_W-1:0] far_lvl,
    input wire logic far_cts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // wire level: the bank wins where it drives, the far device elsewhere
    always_comb begin
        for (int i = 0; i < GPIO_W; i++) begin
            gpio_in[i] = gpio_oe[i] ? gpio_out[i] : far_lvl[i];
        end
        cts_pin_n = far_cts_n;
    end
endmodule

// >>> testbench/uart_aux_regs_tb_top.sv
// testbench: aux register bank driven over apb, peer model on the pins
module uart_aux_regs_tb_top
    import uart_aux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------
    // signals
    // ----------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] tx_space = 7'h00;
    logic [6:0] rx_count = 7'h00;
    logic cts_pin_n;
    logic [7:0] gpio_in, gpio_out, gpio_oe;
    logic [7:0] far_lvl = 8'hFF; // far side idles inactive high
    logic far_cts_n = 1'b1;
    levels_s levels;
    logic modem_irq, pin_irq;
    logic [31:0] rd; // last read data
    logic err; // last slave error
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    // ----------------------------
    // design and peer
    // ----------------------------
    uart_aux_regs #(.GPIO_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_space(tx_space),
        .rx_count(rx_count), .cts_pin_n(cts_pin_n), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .levels(levels),
        .modem_irq(modem_irq), .pin_irq(pin_irq));
    modem_line_peer #(.GPIO_W(8)) peer (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_in(gpio_in), .cts_pin_n(cts_pin_n), .far_lvl(far_lvl), .far_cts_n(far_cts_n));
    // clock and hang guard
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    // ----------------------------
    // tasks
    // ----------------------------
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask
    // ----------------------------
    // scenarios
    // ----------------------------
    task automatic t_basic();
        rdc(ADDR_SCRATCH_BYTE, {24'h0, RST_BYTE});
        rdc(ADDR_PIN_DIRECTION, {24'h0, RST_BYTE});
        xfer(1'b0, 8'h3C, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(ADDR_SCRATCH_BYTE, 32'hFFFF_FFA5);
        rdc(ADDR_SCRATCH_BYTE, 32'h0000_00A5);
        tx_space <= 7'h40;
        wr(ADDR_TX_FREE_SPACE, 32'hFF);
        rdc(ADDR_TX_FREE_SPACE, 32'h40);
        rdc(ADDR_RX_FILL, 32'h00);
        tx_space <= 7'h00;
        rx_count <= 7'h40;
        rdc(ADDR_TX_FREE_SPACE, 32'h00);
        rdc(ADDR_RX_FILL, 32'h40);
        $display("test basic done");
    endtask
    task automatic t_thresh();
        chk({31'h0, levels.use_fcr_flow}, 32'h1);
        wr(ADDR_FLOW_THRESHOLD, 32'h2F);
        rdc(ADDR_FLOW_THRESHOLD, 32'h00);
        wr(ADDR_AUX_CONTROL, 32'h0050_0300);
        wr(ADDR_FLOW_THRESHOLD, 32'h2F); // halt above resume
        rdc(ADDR_FLOW_THRESHOLD, 32'h2F);
        wr(ADDR_TRIGGER_LEVEL, 32'h30); // fifo rx trigger left zero
        settle();
        chk({25'h0, levels.halt_cnt}, 32'd60);
        chk({25'h0, levels.resume_cnt}, 32'd8);
        chk({31'h0, levels.use_fcr_flow}, 32'h0);
        chk({25'h0, levels.rx_trig_cnt}, 32'd12);
        chk({25'h0, levels.tx_trig_cnt}, 32'd20);
        $display("test thresholds done");
    endtask
    task automatic t_gpio();
        far_lvl <= 8'h30;
        wr(ADDR_PIN_DIRECTION, 32'h0F);
        wr(ADDR_PIN_LEVEL, 32'hA5);
        settle();
        chk({24'h0, gpio_oe}, 32'h0F);
        chk({24'h0, gpio_out & gpio_oe}, 32'h05);
        rdc(ADDR_PIN_LEVEL, 32'h35);
        wr(ADDR_PIN_IRQ_ENABLE, 32'h10);
        far_lvl <= 8'h20;
        settle();
        chk({31'h0, pin_irq}, 32'h1);
        xfer(1'b0, ADDR_PIN_CHANGE, 32'h0);
        far_lvl <= 8'h60;
        settle();
        chk({31'h0, pin_irq}, 32'h0);
        $display("test gpio done");
    endtask
    task automatic t_modem();
        wr(ADDR_PIN_DIRECTION, 32'h00);
        wr(ADDR_PIN_IRQ_ENABLE, 32'h0F);
        far_lvl <= 8'hFF;
        far_cts_n <= 1'b0;
        settle();
        xfer(1'b0, ADDR_PIN_CHANGE, 32'h0);
        rdc(ADDR_MODEM_LINE_STATUS, 32'h11);
        rdc(ADDR_MODEM_LINE_STATUS, 32'h10);
        far_cts_n <= 1'b1;
        wr(ADDR_AUX_CONTROL, 32'h2004);
        settle();
        rdc(ADDR_MODEM_LINE_STATUS, 32'h01);
        far_lvl <= 8'hFB;
        settle();
        chk({31'h0, modem_irq}, 32'h1);
        rdc(ADDR_MODEM_LINE_STATUS, 32'h88);
        far_lvl <= 8'hF3;
        settle();
        rdc(ADDR_MODEM_LINE_STATUS, 32'hC0);
        far_lvl <= 8'hFB;
        settle();
        rdc(ADDR_MODEM_LINE_STATUS, 32'h84);
        far_lvl <= 8'hFA;
        settle();
        rdc(ADDR_MODEM_LINE_STATUS, 32'hA2);
        chk({31'h0, pin_irq}, 32'h0);
        wr(ADDR_AUX_CONTROL, 32'h0C00);
        settle();
        xfer(1'b0, ADDR_MODEM_LINE_STATUS, 32'h0);
        chk(rd & 32'hF0, 32'h20);
        $display("test modem done");
    endtask
    // ----------------------------
    // main sequence
    // ----------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_basic();
        t_thresh();
        t_gpio();
        t_modem();
        print_verdict();
    end
endmodule
